// [src/pbs_fifo.sv]
// First-word fall-through FIFO that buffers read words before the pins.
`include "pbs_params.svh"
`default_nettype none
module pbs_fifo #(
    parameter int W     = 37,
    parameter int DEPTH = `PBS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           rst_b_i,
    // Filling side
    input  wire logic           in_valid_i,
    output var  logic           in_ready_o,
    input  wire logic [W-1:0]   in_data_i,
    // Draining side
    output var  logic           out_valid_o,
    input  wire logic           out_ready_i,
    output var  logic [W-1:0]   out_data_o
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  ring [DEPTH-1:0];
    logic [PW-1:0] wp_ff;
    logic [PW-1:0] rp_ff;
    logic [CW-1:0] cnt_ff;
    logic          empty;
    logic          bypass;
    logic          push;
    logic          pop;

    // ======================================================================
    // Flags
    // ======================================================================
    // An empty ring hands the incoming word straight through, so the buffer
    // adds no latency while the pins drain every cycle.
    assign empty       = (cnt_ff == '0);
    assign in_ready_o  = (cnt_ff < CW'(DEPTH));
    assign out_valid_o = !empty || in_valid_i;
    assign out_data_o  = empty ? in_data_i : ring[rp_ff];
    assign bypass      = empty && out_ready_i;
    assign push        = in_valid_i && in_ready_o && !bypass;
    assign pop         = !empty && out_ready_i;

    // ======================================================================
    // Storage and pointers
    // ======================================================================
    always_ff @(posedge clk_i) begin
        if (push) begin
            ring[wp_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == PW'(DEPTH - 1)) ? '0 : wp_ff + PW'(1);
            end
            if (pop) begin
                rp_ff <= (rp_ff == PW'(DEPTH - 1)) ? '0 : rp_ff + PW'(1);
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + CW'(1);
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - CW'(1);
            end
        end
    end

endmodule
`default_nettype wire

// [src/pbs_mem.sv]
// Storage array with per-lane write enables and a registered read port.
`include "pbs_params.svh"
`default_nettype none
module pbs_mem #(
    parameter int AW     = `PBS_ADDR_W,
    parameter int LANES  = `PBS_LANES,
    parameter int LANE_W = `PBS_LANE_W
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_b_i,
    // Access port
    input  wire logic [AW-1:0]             addr_i,
    input  wire logic                      we_i,
    input  wire logic [LANES-1:0]          be_i,
    input  wire logic [LANES*LANE_W-1:0]   wdata_i,
    input  wire logic                      re_i,
    output var  logic [LANES*LANE_W-1:0]   rdata_o
);

    // ======================================================================
    // One column of storage per byte lane
    // ======================================================================
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : g_lane
            logic [LANE_W-1:0] arr [(2**AW)-1:0];

            always_ff @(posedge clk_i) begin
                if (we_i && be_i[g]) begin
                    arr[addr_i] <= wdata_i[g*LANE_W +: LANE_W];
                end
            end

            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    rdata_o[g*LANE_W +: LANE_W] <= '0;
                end else if (re_i) begin
                    rdata_o[g*LANE_W +: LANE_W] <= arr[addr_i];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// [src/pbs_params.svh]
// Constants shared by the burst SRAM port: widths, sizes and reset values.
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// ==========================================================================
// Array shape
// ==========================================================================
`define PBS_ADDR_W      21
`define PBS_DATA_W      36
`define PBS_LANES       4
`define PBS_LANE_W      9
`define PBS_BURST_W     2

// ==========================================================================
// Read data buffer
// ==========================================================================
`define PBS_FIFO_DEPTH  8

// ==========================================================================
// Reset values, lane masks and burst step
// ==========================================================================
`define PBS_BURST_RST   2'h0
`define PBS_LANES_OFF   4'h0
`define PBS_LANES_ALL   4'hF
`define PBS_STEP        2'h1

`endif

// [src/pbs_pkg.sv]
// Types shared by the burst SRAM port modules.
`include "pbs_params.svh"
`default_nettype none
package pbs_pkg;

    // ======================================================================
    // Sampled bus inputs
    // ======================================================================
    typedef struct packed {
        logic [`PBS_ADDR_W-1:0]  addr;
        logic                    proc_stb_n;
        logic                    ctrl_stb_n;
        logic                    adv_n;
        logic                    sel_a_n;
        logic                    sel_b;
        logic                    sel_c_n;
        logic                    gw_n;
        logic                    bwe_n;
        logic [`PBS_LANES-1:0]   bws_n;
        logic [`PBS_DATA_W-1:0]  wdata;
    } pbs_bus_t;

    // ======================================================================
    // Read word travelling through the buffer
    // ======================================================================
    typedef struct packed {
        logic [`PBS_DATA_W-1:0]  data;
        logic                    mask_oe;
    } pbs_rd_t;

    typedef enum logic [1:0] {
        PBS_DESEL  = 2'h1,
        PBS_ACTIVE = 2'h2
    } pbs_state_t;

endpackage
`default_nettype wire

// [src/pbs_sram_port.sv]
// Pipelined synchronous burst SRAM port: bus sampling, burst counter, array.
`include "pbs_params.svh"
`default_nettype none
module pbs_sram_port #(
    parameter int FIFO_DEPTH = `PBS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_b_i,
    // Address and access control
    input  wire logic [`PBS_ADDR_W-1:0]  addr_i,
    input  wire logic                    proc_addr_strobe_n_i,
    input  wire logic                    ctrl_addr_strobe_n_i,
    input  wire logic                    burst_advance_n_i,
    input  wire logic                    chip_sel_a_n_i,
    input  wire logic                    chip_sel_b_i,
    input  wire logic                    chip_sel_c_n_i,
    // Write control
    input  wire logic                    all_byte_write_n_i,
    input  wire logic                    byte_write_enable_n_i,
    input  wire logic [`PBS_LANES-1:0]   byte_lane_select_n_i,
    // Configuration
    input  wire logic                    linear_burst_i,
    // Asynchronous pins
    input  wire logic                    out_enable_n_i,
    input  wire logic                    sleep_req_i,
    // Data pins
    input  wire logic [`PBS_DATA_W-1:0]  dq_i,
    output var  logic [`PBS_DATA_W-1:0]  dq_o,
    output var  logic                    dq_oe_o,
    // Buffer status
    output var  logic                    rd_room_o
);

    localparam int RW = $bits(pbs_pkg::pbs_rd_t);

    pbs_pkg::pbs_bus_t    bus_ff;
    pbs_pkg::pbs_state_t  state_ff;
    logic [`PBS_ADDR_W-1:0]  base_ff;
    logic [`PBS_BURST_W-1:0] start_ff;
    logic [`PBS_BURST_W-1:0] cnt_ff;
    logic [`PBS_BURST_W-1:0] nxt_cnt;
    logic [`PBS_BURST_W-1:0] burst_low;
    logic [`PBS_ADDR_W-1:0]  acc_addr;
    logic [`PBS_LANES-1:0]   wr_lanes;
    logic        oe_meta_ff;
    logic        oe_s_ff;
    logic        zz_meta_ff;
    logic        zz_s_ff;
    logic        load;
    logic        selected;
    logic        advance;
    logic        access;
    logic        is_write;
    logic        rd_pend_ff;
    logic        mask_pend_ff;
    logic        first_mask;
    logic [`PBS_DATA_W-1:0] mem_rdata;
    pbs_pkg::pbs_rd_t fifo_in;
    pbs_pkg::pbs_rd_t fifo_out;
    logic [RW-1:0]    fifo_out_bits;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        drain;
    logic [`PBS_DATA_W-1:0] dq_o_ff;
    logic        dq_oe_o_ff;
    logic        rd_room_o_ff;

    // ======================================================================
    // Bus sampling
    // ======================================================================
    // Every synchronous pin is caught once; all decisions below look only at
    // this copy, so every input sees the same edge.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_ff.addr       <= '0;
            bus_ff.proc_stb_n <= 1'b1;
            bus_ff.ctrl_stb_n <= 1'b1;
            bus_ff.adv_n      <= 1'b1;
            bus_ff.sel_a_n    <= 1'b1;
            bus_ff.sel_b      <= 1'b0;
            bus_ff.sel_c_n    <= 1'b1;
            bus_ff.gw_n       <= 1'b1;
            bus_ff.bwe_n      <= 1'b1;
            bus_ff.bws_n      <= `PBS_LANES_ALL;
            bus_ff.wdata      <= '0;
        end else begin
            bus_ff.addr       <= addr_i;
            bus_ff.proc_stb_n <= proc_addr_strobe_n_i;
            bus_ff.ctrl_stb_n <= ctrl_addr_strobe_n_i;
            bus_ff.adv_n      <= burst_advance_n_i;
            bus_ff.sel_a_n    <= chip_sel_a_n_i;
            bus_ff.sel_b      <= chip_sel_b_i;
            bus_ff.sel_c_n    <= chip_sel_c_n_i;
            bus_ff.gw_n       <= all_byte_write_n_i;
            bus_ff.bwe_n      <= byte_write_enable_n_i;
            bus_ff.bws_n      <= byte_lane_select_n_i;
            bus_ff.wdata      <= dq_i;
        end
    end

    // ======================================================================
    // Asynchronous pins
    // ======================================================================
    // Output enable and sleep do not wait for the bus edge; each crosses two flops,
    // then output enable gates the pin driver and sleep blocks loads, advances and draining.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            oe_meta_ff <= 1'b0;
            oe_s_ff    <= 1'b0;
            zz_meta_ff <= 1'b0;
            zz_s_ff    <= 1'b0;
        end else begin
            oe_meta_ff <= !out_enable_n_i;
            oe_s_ff    <= oe_meta_ff;
            zz_meta_ff <= sleep_req_i;
            zz_s_ff    <= zz_meta_ff;
        end
    end

    // ======================================================================
    // Access decode
    // ======================================================================
    // The processor strobe is ignored while the first chip select is high;
    // the controller strobe is not.
    assign load = !zz_s_ff
               && ((!bus_ff.proc_stb_n && !bus_ff.sel_a_n)
               ||  !bus_ff.ctrl_stb_n);
    assign selected = !bus_ff.sel_a_n && bus_ff.sel_b
                   && !bus_ff.sel_c_n;
    assign advance = !load && !zz_s_ff && !bus_ff.adv_n
                  && (state_ff == pbs_pkg::PBS_ACTIVE);
    assign access  = (load && selected) || advance;

    assign nxt_cnt = cnt_ff + `PBS_STEP;
    // Linear order wraps inside the four-word block; interleaved order
    // flips address bits. The order input must not move mid burst.
    assign burst_low = linear_burst_i ? (start_ff + nxt_cnt)
                                      : (start_ff ^ nxt_cnt);
    assign acc_addr = load ? bus_ff.addr
                           : {base_ff[`PBS_ADDR_W-1:`PBS_BURST_W],
                              burst_low};

    // ======================================================================
    // Write lanes
    // ======================================================================
    always_comb begin
        if (!bus_ff.gw_n) begin
            wr_lanes = `PBS_LANES_ALL;
        end else if (!bus_ff.bwe_n) begin
            wr_lanes = ~bus_ff.bws_n;
        end else begin
            wr_lanes = `PBS_LANES_OFF;
        end
    end
    assign is_write = access && (wr_lanes != `PBS_LANES_OFF);

    // ======================================================================
    // Burst state and counter
    // ======================================================================
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= pbs_pkg::PBS_DESEL;
        end else if (load) begin
            case (selected)
                1'b1:    state_ff <= pbs_pkg::PBS_ACTIVE;
                default: state_ff <= pbs_pkg::PBS_DESEL;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            base_ff  <= '0;
            start_ff <= `PBS_BURST_RST;
            cnt_ff   <= `PBS_BURST_RST;
        end else if (load && selected) begin
            base_ff  <= bus_ff.addr;
            start_ff <= bus_ff.addr[`PBS_BURST_W-1:0];
            cnt_ff   <= `PBS_BURST_RST;
        end else if (advance) begin
            cnt_ff   <= nxt_cnt;
        end
    end

    // A read that opens from the deselected state hides its first word.
    assign first_mask = load && (state_ff == pbs_pkg::PBS_DESEL);

    // ======================================================================
    // Array
    // ======================================================================
    // Write data were caught with the address, so the array write runs on
    // its own on the next edge with nothing more asked of the host.
    pbs_mem #(
        .AW     (`PBS_ADDR_W),
        .LANES  (`PBS_LANES),
        .LANE_W (`PBS_LANE_W)
    ) u_mem (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .addr_i  (acc_addr),
        .we_i    (is_write),
        .be_i    (wr_lanes),
        .wdata_i (bus_ff.wdata),
        .re_i    (access && !is_write),
        .rdata_o (mem_rdata)
    );

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_pend_ff   <= 1'b0;
            mask_pend_ff <= 1'b0;
        end else begin
            rd_pend_ff   <= access && !is_write;
            mask_pend_ff <= first_mask;
        end
    end

    // ======================================================================
    // Read buffer
    // ======================================================================
    // The pins drain one word per clock except in sleep; a word that meets
    // a full buffer is lost, which rd_room_o reports one clock late.
    assign fifo_in.data    = mem_rdata;
    assign fifo_in.mask_oe = mask_pend_ff;
    assign drain           = !zz_s_ff;
    assign fifo_out        = pbs_pkg::pbs_rd_t'(fifo_out_bits);

    pbs_fifo #(
        .W     (RW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (rd_pend_ff),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (drain),
        .out_data_o  (fifo_out_bits)
    );

    // ======================================================================
    // Output registers
    // ======================================================================
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_o_ff <= '0;
        end else if (fifo_out_valid && drain) begin
            dq_o_ff <= fifo_out.data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_oe_o_ff <= 1'b0;
        end else begin
            dq_oe_o_ff <= fifo_out_valid && drain
                       && !fifo_out.mask_oe
                       && oe_s_ff
                       && !(load && !selected);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_room_o_ff <= 1'b1;
        end else begin
            rd_room_o_ff <= fifo_in_ready;
        end
    end

    assign dq_o      = dq_o_ff;
    assign dq_oe_o   = dq_oe_o_ff;
    assign rd_room_o = rd_room_o_ff;

endmodule
`default_nettype wire

// [tb/pbs_host.sv]
// Host model that drives the synchronous bus of the burst SRAM port.
`include "pbs_params.svh"
`default_nettype none
module pbs_host (
    // Clock
    input  wire logic             clk_i,
    // Bus pins
    output var pbs_pkg::pbs_bus_t bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial bus_o = '1;
    // A request is set up after a falling edge and held across one rising
    // edge; idle requests carry fresh random address and data.
    task automatic put(input pbs_pkg::pbs_bus_t c);
        @(negedge clk_i);
        bus_o = c;
    endtask
endmodule
`default_nettype wire

// [tb/pbs_sram_port_monitor.sv]
// Pin-level assertions for the burst SRAM port.
`include "pbs_params.svh"
`default_nettype none
module pbs_sram_port_monitor #(
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic                   clk_i,
    input wire logic                   rst_b_i,
    // Bus controls
    input wire logic                   proc_addr_strobe_n_i,
    input wire logic                   ctrl_addr_strobe_n_i,
    input wire logic                   burst_advance_n_i,
    input wire logic                   chip_sel_a_n_i,
    input wire logic                   chip_sel_b_i,
    input wire logic                   chip_sel_c_n_i,
    input wire logic                   all_byte_write_n_i,
    input wire logic                   byte_write_enable_n_i,
    input wire logic [`PBS_LANES-1:0]  byte_lane_select_n_i,
    // Asynchronous pins
    input wire logic                   out_enable_n_i,
    input wire logic                   sleep_req_i,
    // Outputs
    input wire logic [`PBS_DATA_W-1:0] dq_o,
    input wire logic                   dq_oe_o,
    input wire logic                   rd_room_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Helper logic
    // ======================================================================
    // Sleep and output enable cross synchronisers, so most checks wait
    // until both have been quiet long enough for the buffer to drain.
    logic [3:0] calm_ff;
    logic [3:0] oe_off_ff;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) calm_ff <= 4'h0;
        else if (sleep_req_i || out_enable_n_i) calm_ff <= 4'h0;
        else if (calm_ff != 4'hF) calm_ff <= calm_ff + 4'h1;
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) oe_off_ff <= 4'h0;
        else if (!out_enable_n_i) oe_off_ff <= 4'h0;
        else if (oe_off_ff != 4'hF) oe_off_ff <= oe_off_ff + 4'h1;
    end
    wire logic calm = calm_ff > 4'hB;
    wire logic sel  = !chip_sel_a_n_i && chip_sel_b_i && !chip_sel_c_n_i;
    wire logic load = (!proc_addr_strobe_n_i && !chip_sel_a_n_i)
                      || !ctrl_addr_strobe_n_i;
    // A byte write with no lane selected stores nothing and reads instead.
    wire logic rd   = all_byte_write_n_i
                      && (byte_write_enable_n_i || &byte_lane_select_n_i);
    wire logic step = !load && !burst_advance_n_i && rd;
    wire logic acc  = (load && sel && rd) || step;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence rd_ld_s; calm && load && sel && rd; endsequence
    sequence desel_s; calm && load && !sel; endsequence
    sequence step_s;  calm && step; endsequence
    // A deselect tristates the pins one clock on and drops a word in flight.
    sequence keep_s;  !(load && !sel); endsequence

    desel_oe_a: assert property (desel_s |-> ##2 !dq_oe_o)
        else $error("Data pins driven after a deselect.");
    first_mask_a: assert property (
        desel_s ##1 rd_ld_s |-> ##3 !dq_oe_o)
        else $error("First read after deselect was shown.");
    rd_latency_a: assert property (
        rd_ld_s ##1 rd_ld_s ##1 keep_s |-> ##2 dq_oe_o)
        else $error("Read word late or missing.");
    burst_words_a: assert property (
        rd_ld_s ##1 rd_ld_s ##1 step_s ##1 step_s ##1 keep_s
        |-> dq_oe_o [*3])
        else $error("Burst words not one clock apart.");
    wr_silent_a: assert property (
        calm && load && sel && !rd |-> ##3 !dq_oe_o)
        else $error("Write produced read data.");
    oe_gate_a: assert property (dq_oe_o |-> oe_off_ff < 4'h5)
        else $error("Data driven while output enable high.");
    dq_hold_a: assert property (
        calm && $changed(dq_o) |-> $past(acc, 3))
        else $error("Read data changed without an access.");
    room_idle_a: assert property (calm |-> rd_room_o)
        else $error("Buffer full while draining freely.");
endmodule
`default_nettype wire

// [tb/tb_pipelined_burst_sync_sram_port.sv]
// Self-checking bench for the burst SRAM port.
`include "pbs_params.svh"
`default_nettype none
module tb_pipelined_burst_sync_sram_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_i, rst_b_i, lin, oe_n, slp, dq_oe, room, tail;
    logic [35:0]       dq_o;
    logic [35:0]       mem [int];
    logic [35:0]       exq [$];
    logic [20:0]       base [4];
    pbs_pkg::pbs_bus_t b, c;
    int                errors, samples_checked, seed, r;

    pbs_sram_port dut_u (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(b.addr),
        .proc_addr_strobe_n_i(b.proc_stb_n),
        .ctrl_addr_strobe_n_i(b.ctrl_stb_n),
        .burst_advance_n_i(b.adv_n), .chip_sel_a_n_i(b.sel_a_n),
        .chip_sel_b_i(b.sel_b), .chip_sel_c_n_i(b.sel_c_n),
        .all_byte_write_n_i(b.gw_n), .byte_write_enable_n_i(b.bwe_n),
        .byte_lane_select_n_i(b.bws_n), .linear_burst_i(lin),
        .out_enable_n_i(oe_n), .sleep_req_i(slp), .dq_i(b.wdata),
        .dq_o(dq_o), .dq_oe_o(dq_oe), .rd_room_o(room));
    pbs_host host_u (.clk_i(clk_i), .bus_o(b));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [37:0] seen, input logic [37:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    function automatic pbs_pkg::pbs_bus_t idle();
        idle = '1;
        idle.sel_a_n = 1'b0;
        idle.sel_c_n = 1'b0;
        idle.addr = 21'($random(seed));
        idle.wdata = 36'({$random(seed), $random(seed)});
    endfunction

    function automatic logic [35:0] merge(input logic [35:0] o,
                                          input pbs_pkg::pbs_bus_t q);
        for (int g = 0; g < 4; g++)
            if (!q.gw_n || (!q.bwe_n && !q.bws_n[g]))
                o[9*g +: 9] = q.wdata[9*g +: 9];
        return o;
    endfunction

    function automatic logic [20:0] baddr(input logic [20:0] a,
                                          input logic [1:0] k);
        return {a[20:2], lin ? a[1:0] + k : a[1:0] ^ k};
    endfunction

    task automatic wr(input logic [20:0] a, input logic p, g, e,
                      input logic [3:0] s);
        c = idle();
        c.addr = a;
        c.gw_n = g;
        c.bwe_n = e;
        c.bws_n = s;
        if (p) c.proc_stb_n = 1'b0;
        else c.ctrl_stb_n = 1'b0;
        mem[a] = merge(mem.exists(a) ? mem[a] : 36'h0, c);
        // No lane selected turns the cycle into a read of the old word.
        if (g && (e || &s)) exq.push_back(mem[a]);
        host_u.put(c);
    endtask

    task automatic rd(input logic [20:0] a, input logic p, input int n,
                      input logic show);
        c = idle();
        c.addr = a;
        if (p) c.proc_stb_n = 1'b0;
        else c.ctrl_stb_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            if (k > 0) begin
                c = idle();
                c.adv_n = 1'b0;
            end
            if (show || k > 0) exq.push_back(mem[baddr(a, k[1:0])]);
            host_u.put(c);
        end
        tail = show || n > 1;
    endtask

    // Any shown word must match the oldest expected one.
    always @(negedge clk_i) begin
        if (rst_b_i === 1'b1 && dq_oe === 1'b1) begin
            if (exq.size() == 0) chk(38'h0, 38'h1);
            else chk({2'b00, dq_o}, {2'b00, exq.pop_front()});
        end
    end

    initial begin
        seed = 45;
        errors = 0;
        samples_checked = 0;
        lin = 1'b0;
        oe_n = 1'b0;
        slp = 1'b0;
        rst_b_i = 1'b0;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        rst_b_i = 1'b1;
        chk({dq_oe, room, dq_o}, {2'b01, 36'h0});
        for (int i = 0; i < 4; i++) begin
            base[i] = 21'($random(seed)) & ~21'h3;
            for (int k = 0; k < 4; k++)
                wr(base[i] + 21'(k), k[0], 1'b0, 1'b1, 4'hF);
        end
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            wr(base[r[9:8]] + 21'(r[11:10]), r[12], r[1:0] != 2'h0,
               r[2] && r[1:0] == 2'h0, r[6:3]);
        end
        repeat (4) host_u.put(idle());
        for (int m = 0; m < 2; m++) begin
            lin = m[0];
            rd(base[0], 1'b0, 1, 1'b1);
            rd(base[1] + 21'h2, 1'b1, 4, 1'b1);
            for (int i = 0; i < 10; i++) begin
                r = $random(seed);
                if (r[3]) begin
                    // A deselect right behind a read drops that read's word.
                    if (tail) void'(exq.pop_back());
                    c = idle();
                    c.ctrl_stb_n = 1'b0;
                    c.sel_b = r[13];
                    c.sel_c_n = r[13];
                    host_u.put(c);
                end
                rd(base[r[5:4]] + 21'(r[7:6]), r[8], int'(r[10:9]) + 1,
                   !r[3]);
                repeat (r[12:11] % 3) host_u.put(idle());
                if (r[12:11] % 3 != 0) tail = 1'b0;
            end
            repeat (4) host_u.put(idle());
        end
        oe_n = 1'b1;
        repeat (5) host_u.put(idle());
        rd(base[2], 1'b0, 1, 1'b0);
        repeat (4) host_u.put(idle());
        oe_n = 1'b0;
        slp = 1'b1;
        repeat (6) host_u.put(idle());
        rd(base[3], 1'b1, 1, 1'b0);
        repeat (4) host_u.put(idle());
        slp = 1'b0;
        repeat (6) host_u.put(idle());
        for (int i = 0; i < 20 && exq.size() > 0; i++) @(negedge clk_i);
        chk(38'(exq.size()), 38'h0);
        end_sim();
    end
endmodule

bind pbs_sram_port pbs_sram_port_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .proc_addr_strobe_n_i(proc_addr_strobe_n_i),
    .ctrl_addr_strobe_n_i(ctrl_addr_strobe_n_i),
    .burst_advance_n_i(burst_advance_n_i), .chip_sel_a_n_i(chip_sel_a_n_i),
    .chip_sel_b_i(chip_sel_b_i), .chip_sel_c_n_i(chip_sel_c_n_i),
    .all_byte_write_n_i(all_byte_write_n_i),
    .byte_write_enable_n_i(byte_write_enable_n_i),
    .byte_lane_select_n_i(byte_lane_select_n_i),
    .out_enable_n_i(out_enable_n_i), .sleep_req_i(sleep_req_i),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .rd_room_o(rd_room_o));
`default_nettype wire
